// [design/dma_active_status.sv]
`timescale 1ns/1ns
// Overview of operation
// - Pending flag clears on execution start, bus error or channel disable.
// - Pending flag sets while a transfer waits on that channel.
// - Active word bits 31:16 show the remaining block count.
// - On a new grant while busy, the active count is written to the old channel's entry.
// - The count is valid only while the busy flag is set.
// - Busy flag clears when the count write-back completes.
// - Busy flag sets when the next count is read from the table.
// - Active word bits 12:8 show the active channel index.
// - Active index updates on an arbiter grant while the sequencer is idle or running.
// - Level flag set while a channel of that level runs or waits.
// - Descriptor base is a 32-bit register, 128-bit aligned.
// - Write-back base is a 32-bit register, 128-bit aligned.
// - Unused bits read zero.
module dma_active_status
    import dma_status_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [7:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [3:0] avs_byteenable_i,
    input wire logic [31:0] avs_writedata_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    input wire chan_evt_s chan_evt_i,
    input wire logic [2*N_CH-1:0] chan_level_i,
    input wire logic grant_valid_i,
    input wire logic [CHSEL_W-1:0] grant_ch_i,
    input wire logic beat_done_i,
    output mem_req_s mem_o,
    input wire logic mem_ack_i,
    input wire logic [15:0] mem_rdata_i,
    output logic [N_CH-1:0] pending_o,
    output logic [CHSEL_W-1:0] chan_sel_o,
    output logic [31:0] desc_base_o,
    output logic irq_o
);

    typedef struct packed {
        seq_e seq;
        logic [N_CH-1:0] pending;
        logic [N_CH-1:0] chan_busy;
        logic [N_LVL-1:0] lvl_exec;
        logic [15:0] cnt;
        logic busy;
        logic [ACT_ID_W-1:0] id;
        logic [ACT_ID_W-1:0] wb_id;
        logic [31:0] desc_base;
        logic [31:0] wb_base;
        logic [7:0] chan_sel;
        logic [N_IRQ-1:0] irq_status;
        logic [N_IRQ-1:0] irq_mask;
        logic irq;
        logic waitreq;
        logic [31:0] rdata;
        mem_req_s mem;
    } state_s;

    state_s s_q;
    state_s s_d;

    logic wr_ok;
    logic rd_start;
    logic [N_IRQ-1:0] irq_evt;
    logic [N_CH-1:0] in_level;

    // Byte-lane merge of a write into a stored word
    function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0] be);
        logic [31:0] r;
        r = old_v;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                r[8*b +: 8] = new_v[8*b +: 8];
            end
        end
        return r;
    endfunction

    // Address of a channel's count halfword in the write-back table
    function automatic logic [31:0] entry_addr(input logic [31:0] base,
                                               input logic [ACT_ID_W-1:0] ch);
        logic [31:0] off;
        off = 32'(ch) << ENTRY_SHIFT;
        return base + off + ENTRY_CNT_OFS;
    endfunction

    // Active status word: count, busy, index, level flags
    function automatic logic [31:0] active_word(input state_s s);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[ACT_CNT_LSB +: 16] = s.cnt;
        w[ACT_BUSY_BIT] = s.busy;
        w[ACT_ID_LSB +: ACT_ID_W] = s.id;
        w[N_LVL-1:0] = s.lvl_exec;
        return w;
    endfunction

    always_comb begin
        s_d = s_q;
        irq_evt = '0;
        in_level = '0;

        // Bus handshake: one wait cycle, then the access completes
        rd_start = (avs_read_i || avs_write_i) && s_q.waitreq;
        wr_ok = avs_write_i && !s_q.waitreq;
        if (rd_start) begin
            s_d.waitreq = 1'b0;
        end else begin
            s_d.waitreq = 1'b1;
        end

        // Pending flags; a new trigger wins over a same-cycle clear
        s_d.pending = s_q.pending & ~(chan_evt_i.exec_start | chan_evt_i.bus_err
                                      | chan_evt_i.disabled);
        s_d.pending = s_d.pending | chan_evt_i.trig_pending;

        // Channel executing flags, used by the level summary
        s_d.chan_busy = s_q.chan_busy & ~(chan_evt_i.exec_done | chan_evt_i.bus_err
                                          | chan_evt_i.disabled);
        s_d.chan_busy = s_d.chan_busy | chan_evt_i.exec_start;

        // Level flags from pending or executing channels
        for (int l = 0; l < N_LVL; l++) begin
            for (int c = 0; c < N_CH; c++) begin
                in_level[c] = (chan_level_i[2*c +: 2] == 2'(l));
            end
            s_d.lvl_exec[l] = |((s_q.pending | s_q.chan_busy) & in_level);
        end

        // Beat progress counts down the active block count
        if (beat_done_i && s_q.busy && s_q.cnt != 16'h0000) begin
            s_d.cnt = s_q.cnt - 16'h0001;
        end

        // Active slot sequencer
        case (s_q.seq)
            SEQ_IDLE, SEQ_RUN: begin
                if (grant_valid_i) begin
                    s_d.id = ACT_ID_W'(grant_ch_i);
                    s_d.wb_id = s_q.id;
                    if (s_q.busy) begin
                        s_d.seq = SEQ_WRITEBACK;
                    end else begin
                        s_d.seq = SEQ_FETCH;
                    end
                end
            end
            SEQ_WRITEBACK: begin
                if (mem_ack_i) begin
                    s_d.busy = 1'b0;
                    s_d.seq = SEQ_FETCH;
                    irq_evt[IRQ_WB_DONE] = 1'b1;
                end
            end
            SEQ_FETCH: begin
                if (mem_ack_i) begin
                    s_d.cnt = mem_rdata_i;
                    s_d.busy = 1'b1;
                    s_d.seq = SEQ_RUN;
                    irq_evt[IRQ_FETCH_DONE] = 1'b1;
                end
            end
            default: begin
                s_d.seq = SEQ_IDLE;
            end
        endcase

        // Memory request follows the next sequencer state
        s_d.mem.req = (s_d.seq == SEQ_WRITEBACK) || (s_d.seq == SEQ_FETCH);
        s_d.mem.we = (s_d.seq == SEQ_WRITEBACK);
        if (s_d.seq == SEQ_WRITEBACK) begin
            s_d.mem.addr = entry_addr(s_q.wb_base, s_d.wb_id);
            s_d.mem.wdata = s_d.cnt;
        end else if (s_d.seq == SEQ_FETCH) begin
            s_d.mem.addr = entry_addr(s_q.wb_base, s_d.id);
            s_d.mem.wdata = 16'h0000;
        end else begin
            s_d.mem.addr = 32'h0000_0000;
            s_d.mem.wdata = 16'h0000;
        end

        irq_evt[IRQ_BUS_ERR] = |chan_evt_i.bus_err;

        // Register writes; the active word has no write path
        if (wr_ok) begin
            case (avs_address_i)
                IDX_DESC_BASE: begin
                    s_d.desc_base = be_merge(s_q.desc_base, avs_writedata_i,
                                             avs_byteenable_i) & BASE_ALIGN_MASK;
                end
                IDX_WB_BASE: begin
                    s_d.wb_base = be_merge(s_q.wb_base, avs_writedata_i,
                                           avs_byteenable_i) & BASE_ALIGN_MASK;
                end
                IDX_IRQ_STATUS: begin
                    if (avs_byteenable_i[0]) begin
                        s_d.irq_status = s_q.irq_status & ~avs_writedata_i[N_IRQ-1:0];
                    end
                end
                IDX_IRQ_MASK: begin
                    if (avs_byteenable_i[0]) begin
                        s_d.irq_mask = avs_writedata_i[N_IRQ-1:0];
                    end
                end
                IDX_CHAN_SELECT: begin
                    if (avs_byteenable_i[0]) begin
                        s_d.chan_sel = {5'h00, avs_writedata_i[CHSEL_W-1:0]};
                    end
                end
                default: begin
                    s_d.chan_sel = s_q.chan_sel;
                end
            endcase
        end

        // Sticky events win over a same-cycle clear
        s_d.irq_status = s_d.irq_status | irq_evt;
        s_d.irq = |(s_d.irq_status & s_d.irq_mask);

        // Read data captured with the answer; unmapped reads give zero
        if (rd_start && avs_read_i) begin
            case (avs_address_i)
                IDX_PENDING: s_d.rdata = {26'h0000000, s_q.pending};
                IDX_ACTIVE: s_d.rdata = active_word(s_q);
                IDX_DESC_BASE: s_d.rdata = s_q.desc_base;
                IDX_WB_BASE: s_d.rdata = s_q.wb_base;
                IDX_IRQ_STATUS: s_d.rdata = {29'h00000000, s_q.irq_status};
                IDX_IRQ_MASK: s_d.rdata = {29'h00000000, s_q.irq_mask};
                IDX_CHAN_SELECT: s_d.rdata = {24'h000000, s_q.chan_sel};
                default: s_d.rdata = RST_RDATA;
            endcase
        end
    end

    // State register with synchronous reset
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            s_q <= '0;
            s_q.seq <= SEQ_IDLE;
            s_q.cnt <= RST_CNT;
            s_q.desc_base <= RST_BASE;
            s_q.wb_base <= RST_BASE;
            s_q.chan_sel <= RST_CHSEL;
            s_q.rdata <= RST_RDATA;
            s_q.waitreq <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs straight from the state register
    assign avs_readdata_o = s_q.rdata;
    assign avs_waitrequest_o = s_q.waitreq;
    assign mem_o = s_q.mem;
    assign pending_o = s_q.pending;
    assign chan_sel_o = s_q.chan_sel[CHSEL_W-1:0];
    assign desc_base_o = s_q.desc_base;
    assign irq_o = s_q.irq;

endmodule // dma_active_status

// [design/dma_status_pkg.sv]
package dma_status_pkg;

    // Register indices; the byte address is four times the index
    localparam logic [7:0] IDX_PENDING = 8'h2c;
    localparam logic [7:0] IDX_ACTIVE = 8'h30;
    localparam logic [7:0] IDX_DESC_BASE = 8'h34;
    localparam logic [7:0] IDX_WB_BASE = 8'h38;
    localparam logic [7:0] IDX_IRQ_STATUS = 8'h3c;
    localparam logic [7:0] IDX_IRQ_MASK = 8'h3d;
    localparam logic [7:0] IDX_CHAN_SELECT = 8'h3f;

    // Sizes
    localparam int N_CH = 6;
    localparam int N_LVL = 4;
    localparam int N_IRQ = 3;

    // Active status word layout, then the channel select width
    localparam int ACT_CNT_LSB = 16;
    localparam int ACT_BUSY_BIT = 15;
    localparam int ACT_ID_LSB = 8;
    localparam int ACT_ID_W = 5;
    localparam int CHSEL_W = 3;

    // Interrupt status bit positions
    localparam int IRQ_WB_DONE = 0;
    localparam int IRQ_FETCH_DONE = 1;
    localparam int IRQ_BUS_ERR = 2;

    // Table layout: 128-bit entries, count halfword at byte 2
    localparam logic [31:0] BASE_ALIGN_MASK = 32'hffff_fff0;
    localparam int ENTRY_SHIFT = 4;
    localparam logic [31:0] ENTRY_CNT_OFS = 32'h0000_0002;

    // Reset values
    localparam logic [31:0] RST_BASE = 32'h0000_0000;
    localparam logic [15:0] RST_CNT = 16'h0000;
    localparam logic [7:0] RST_CHSEL = 8'h00;
    localparam logic [31:0] RST_RDATA = 32'h0000_0000;

    typedef enum logic [1:0] {
        SEQ_IDLE = 2'b00,
        SEQ_WRITEBACK = 2'b01,
        SEQ_FETCH = 2'b10,
        SEQ_RUN = 2'b11
    } seq_e;

    // Per-channel events from the channel logic
    typedef struct packed {
        logic [N_CH-1:0] trig_pending;
        logic [N_CH-1:0] exec_start;
        logic [N_CH-1:0] exec_done;
        logic [N_CH-1:0] bus_err;
        logic [N_CH-1:0] disabled;
    } chan_evt_s;

    // Request toward system memory
    typedef struct packed {
        logic req;
        logic we;
        logic [31:0] addr;
        logic [15:0] wdata;
    } mem_req_s;

endpackage

// [dv/dma_active_status_properties.sv]
`timescale 1ns/1ns
module dma_status_checker
    import dma_status_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [7:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [3:0] avs_byteenable_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [31:0] avs_readdata_o,
    input wire logic avs_waitrequest_o,
    input wire chan_evt_s chan_evt_i,
    input wire logic grant_valid_i,
    input wire mem_req_s mem_o,
    input wire logic mem_ack_i,
    input wire logic [N_CH-1:0] pending_o,
    input wire logic [CHSEL_W-1:0] chan_sel_o,
    input wire logic [31:0] desc_base_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    // Completed write and clearing events
    logic wr_done;
    logic [N_CH-1:0] clr;
    assign wr_done = avs_write_i && !avs_waitrequest_o;
    assign clr = chan_evt_i.exec_start | chan_evt_i.bus_err | chan_evt_i.disabled;
    sequence s_wb_ack;
        mem_o.req && mem_o.we && mem_ack_i;
    endsequence
    sequence s_fetch;
        mem_o.req && !mem_o.we;
    endsequence
    AST_PEND_CLR: assert property (##1
        (pending_o & $past(clr & ~chan_evt_i.trig_pending)) == '0)
        else $error("pending flag not cleared");
    AST_PEND_SET: assert property (##1
        (pending_o & $past(chan_evt_i.trig_pending)) == $past(chan_evt_i.trig_pending))
        else $error("pending flag not set");
    AST_GRANT: assert property (grant_valid_i && !mem_o.req |=> mem_o.req)
        else $error("grant started no table access");
    AST_WB_THEN_FETCH: assert property (s_wb_ack |=> s_fetch)
        else $error("write-back not followed by fetch");
    AST_FETCH_END: assert property (s_fetch ##0 mem_ack_i |=> !mem_o.req)
        else $error("request held after fetch");
    AST_ENTRY: assert property (mem_o.req |-> mem_o.addr[3:0] == 4'h2)
        else $error("table entry misaligned");
    AST_BUS: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
        |=> !avs_waitrequest_o ##1 avs_waitrequest_o)
        else $error("bus answer wrong");
    AST_DESC: assert property (wr_done && avs_address_i == IDX_DESC_BASE
        && avs_byteenable_i == 4'hf
        |=> desc_base_o == ($past(avs_writedata_i) & BASE_ALIGN_MASK))
        else $error("descriptor base wrong");
    AST_CHSEL: assert property (wr_done && avs_address_i == IDX_CHAN_SELECT
        && avs_byteenable_i[0] |=> chan_sel_o == $past(avs_writedata_i[2:0]))
        else $error("channel select wrong");
    AST_UNMAPPED: assert property (avs_read_i && !avs_waitrequest_o
        && avs_address_i == 8'h00 |-> avs_readdata_o == '0)
        else $error("unmapped read not zero");
endmodule // dma_status_checker
bind dma_active_status dma_status_checker dma_status_checker_i (.clk_i, .rst_n_i,
    .avs_address_i, .avs_read_i, .avs_write_i, .avs_byteenable_i, .avs_writedata_i,
    .avs_readdata_o, .avs_waitrequest_o, .chan_evt_i, .grant_valid_i, .mem_o,
    .mem_ack_i, .pending_o, .chan_sel_o, .desc_base_o);

// [dv/mem_model.sv]
`timescale 1ns/1ns
module mem_model
    import dma_status_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire mem_req_s mem_i,
    input wire logic [3:0] lat_i,
    output logic mem_ack_o,
    output logic [15:0] mem_rdata_o
);
    logic [15:0] cell_q [0:7];
    logic [3:0] cnt_q;
    // Answer after lat_i cycles; data scrambled when not answering
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            cnt_q <= 4'h0;
            mem_ack_o <= 1'b0;
            mem_rdata_o <= 16'h0000;
            for (int i = 0; i < 8; i++) cell_q[i] <= 16'h0005 + 16'(i * 16);
        end else if (mem_i.req && !mem_ack_o && cnt_q == lat_i) begin
            mem_ack_o <= 1'b1;
            cnt_q <= 4'h0;
            mem_rdata_o <= cell_q[mem_i.addr[6:4]];
            if (mem_i.we) cell_q[mem_i.addr[6:4]] <= mem_i.wdata;
        end else begin
            mem_ack_o <= 1'b0;
            cnt_q <= (mem_i.req && !mem_ack_o) ? cnt_q + 4'h1 : 4'h0;
            mem_rdata_o <= ~mem_rdata_o;
        end
    end
endmodule // mem_model

// [dv/tb_dma_active_status.sv]
`timescale 1ns/1ns
module tb_dma_active_status
    import dma_status_pkg::*;
;
    logic clk_i, rst_n_i, rd, wr, wt, gv, beat, ack, irq;
    logic [7:0] adr;
    logic [31:0] wd, rdt, dbase, q;
    logic [15:0] mrd;
    logic [11:0] lvl;
    logic [3:0] lat, be;
    logic [2:0] gch, csel;
    logic [5:0] pend;
    logic x;
    chan_evt_s evt;
    mem_req_s mem;
    int n_errors = 0;
    int check_count = 0;
    dma_active_status dma_active_status_i (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr), .avs_byteenable_i(be),
        .avs_writedata_i(wd), .avs_readdata_o(rdt), .avs_waitrequest_o(wt),
        .chan_evt_i(evt), .chan_level_i(lvl), .grant_valid_i(gv), .grant_ch_i(gch),
        .beat_done_i(beat), .mem_o(mem), .mem_ack_i(ack), .mem_rdata_i(mrd),
        .pending_o(pend), .chan_sel_o(csel), .desc_base_o(dbase), .irq_o(irq));
    mem_model mem_model_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .mem_i(mem), .lat_i(lat),
        .mem_ack_o(ack), .mem_rdata_o(mrd));
    // Clock
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            $display("[FAIL] %s exp %h got %h", n, e, g);
            n_errors++;
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        adr <= a;
        wd <= d;
        rd <= !w;
        wr <= w;
        do @(posedge clk_i); while (wt !== 1'b0);
        q = rdt;
        rd <= 1'b0;
        wr <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] e, input string n);
        bus(1'b0, a, 32'h0);
        chk(n, e, q);
    endtask
    task automatic pulse(input int k, input logic [5:0] m);
        evt <= chan_evt_s'(30'(m) << (6 * k));
        @(posedge clk_i);
        evt <= '0;
        @(posedge clk_i);
    endtask
    task automatic await(input logic w);
        do @(posedge clk_i); while (!(ack === 1'b1 && mem.we === w));
        @(posedge clk_i);
    endtask
    task automatic t_regs();
        rc(IDX_ACTIVE, 32'h0, "active");
        rc(IDX_DESC_BASE, 32'h0, "desc");
        rc(IDX_WB_BASE, 32'h0, "wb");
        rc(8'h00, 32'h0, "unmapped");
        bus(1'b1, IDX_DESC_BASE, 32'h1234_567f);
        rc(IDX_DESC_BASE, 32'h1234_5670, "desc");
        chk("desc_o", 32'h1234_5670, dbase);
        be <= 4'h1;
        bus(1'b1, IDX_DESC_BASE, 32'hffff_ffff);
        be <= 4'hf;
        rc(IDX_DESC_BASE, 32'h1234_56f0, "desc lane0");
        bus(1'b1, IDX_WB_BASE, 32'h0000_100c);
        rc(IDX_WB_BASE, 32'h0000_1000, "wb");
        bus(1'b1, IDX_CHAN_SELECT, 32'h0000_00ff);
        rc(IDX_CHAN_SELECT, 32'h7, "chsel");
        chk("chsel_o", 32'h7, 32'(csel));
        bus(1'b1, IDX_ACTIVE, 32'hffff_ffff);
        rc(IDX_ACTIVE, 32'h0, "active ro");
    endtask
    task automatic t_pend();
        lvl <= 12'h0c0;
        for (int k = 1; k < 4; k++) begin
            pulse(4, 6'h08);
            rc(IDX_PENDING, 32'h08, "pending");
            chk("pending_o", 32'h08, 32'(pend));
            rc(IDX_ACTIVE, 32'h08, "level");
            pulse(k == 2 ? 0 : k, 6'h08);
            rc(IDX_PENDING, 32'h0, "cleared");
            chk("pending_o off", 32'h0, 32'(pend));
        end
        pulse(2, 6'h08);
        rc(IDX_ACTIVE, 32'h0, "level off");
    endtask
    task automatic t_grant();
        gch <= 3'd3;
        gv <= 1'b1;
        @(posedge clk_i);
        gv <= 1'b0;
        await(1'b0);
        rc(IDX_ACTIVE, 32'h0035_8300, "fetch");
        beat <= 1'b1;
        repeat (2) @(posedge clk_i);
        beat <= 1'b0;
        rc(IDX_ACTIVE, 32'h0033_8300, "count");
        lat <= 4'h6;
        gch <= 3'd5;
        gv <= 1'b1;
        @(posedge clk_i);
        gv <= 1'b0;
        await(1'b1);
        bus(1'b0, IDX_ACTIVE, 32'h0);
        chk("busy off", 32'h0, q & 32'h8000);
        await(1'b0);
        chk("stored", 32'h0033, 32'(mem_model_i.cell_q[3]));
        rc(IDX_ACTIVE, 32'h0055_8500, "regrant");
    endtask
    task automatic t_irq();
        rc(IDX_IRQ_STATUS, 32'h7, "irq status");
        bus(1'b1, IDX_IRQ_MASK, 32'h7);
        x = irq;
        bus(1'b1, IDX_IRQ_MASK, 32'h0);
        chk("irq mask", 32'h1, 32'(x ^ irq));
        bus(1'b1, IDX_IRQ_STATUS, 32'h7);
        rc(IDX_IRQ_STATUS, 32'h0, "irq clear");
        chk("irq off", 32'h0, 32'(irq));
    endtask
    task automatic wrap_up();
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // Watchdog
    initial begin
        repeat (5000) @(posedge clk_i);
        n_errors++;
        wrap_up();
    end
    // Main sequence
    initial begin
        {rst_n_i, rd, wr, gv, beat, adr, wd, lvl, lat, gch} = '0;
        evt = '0;
        be = 4'hf;
        repeat (12) @(posedge clk_i);
        rst_n_i <= 1'b1;
        @(posedge clk_i);
        t_regs();
        t_pend();
        t_grant();
        t_irq();
        wrap_up();
    end
endmodule // tb_dma_active_status
